// [logic/eccr_pkg.sv]
// Contract
// R1 - Encoder makes 8 check bits from data[63:0]
// R2 - Decoder corrects single, detects double errors
// R3 - Single error: corrected word, single flag raised
// R4 - Double error: raw word out, double flag
// R5 - Correction never written back to array
// R6 - Reset clears output registers and both flags
// R7 - Single injection inverts stored bit 30
// R8 - Double injection inverts 30, 62; wins
// R9 - Injection works in every ECC configuration
// R10 - Separate decoder and encoder enable settings
// R11 - Encode-only read: raw word, flags low
// R12 - Decode-only: fabric supplies check bits itself
// R13 - Flags travel with their data word
// R14 - Check-bit errors corrected or flagged too
// R15 - Optional input stage ahead of encoder
// R16 - Two optional output stages around decoder
// R17 - Fabric holds all byte enables high
// R18 - Block selected when masked address matches
// R19 - Read port self address must be unique
// R20 - Shared self address only on write-only port
// R21 - Multi-bit address writes several blocks together
// R22 - Requests enter below, read data leaves above
//
// Constants, carriers and register map of one ECC protected RAM port.
// Assumes a single clock domain and an APB master for configuration.
package eccr_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int ECCR_DATA_W = 64;
   localparam int ECCR_CHK_W = 8;
   localparam int ECCR_WORD_W = ECCR_DATA_W + ECCR_CHK_W;
   localparam int ECCR_LANES = 9;
   localparam int ECCR_SEL_W = 11;
   localparam int ECCR_DEPTH_W = 12;
   localparam int ECCR_ADDR_W = ECCR_DEPTH_W + ECCR_SEL_W;
   localparam int ECCR_CNT_W = 16;

   // ------------------------------------------------------------
   // Error injection positions
   // ------------------------------------------------------------
   localparam int ECCR_INJ_LO = 30;
   localparam int ECCR_INJ_HI = 62;

   // ------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------
   localparam logic [11:0] ECCR_OFS_CTRL = 12'h000;
   localparam logic [11:0] ECCR_OFS_SELF_ADDR = 12'h004;
   localparam logic [11:0] ECCR_OFS_SELF_MASK = 12'h008;
   localparam logic [11:0] ECCR_OFS_STATUS = 12'h00C;
   localparam int ECCR_CTRL_DEC_EN = 0;
   localparam int ECCR_CTRL_ENC_EN = 1;
   localparam int ECCR_CTRL_IN_STAGE = 2;
   localparam int ECCR_CTRL_PRE_STAGE = 3;
   localparam int ECCR_CTRL_POST_STAGE = 4;
   localparam int ECCR_CTRL_W = 5;
   localparam logic [4:0] ECCR_CTRL_RST = 5'h03;
   localparam logic [10:0] ECCR_SELF_ADDR_RST = 11'h000;
   localparam logic [10:0] ECCR_SELF_MASK_RST = 11'h000;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic wr;
      logic [ECCR_ADDR_W-1:0] addr;
      logic [ECCR_WORD_W-1:0] din;
      logic [ECCR_LANES-1:0] byte_write_mask;
      logic inject_single_error;
      logic inject_double_error;
   } eccr_req_t;

   typedef struct packed {
      logic valid;
      logic [ECCR_WORD_W-1:0] data;
      logic single_error_flag;
      logic double_error_flag;
   } eccr_rd_t;

endpackage

// [logic/eccr_port.sv]
// One port of a 4K x 72 RAM block with SECDED encode, decode,
// error injection, optional pipeline stages and cascade selection.
// Assumes the fabric and the block below share clk; APB config bus.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module eccr_port #(
   parameter int DEPTH_W = 12
) (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Request from fabric or from the block below
   input wire eccr_pkg::eccr_req_t req_in,
   // Request passed on to the block above
   output eccr_pkg::eccr_req_t req_out,
   // Read result arriving from the block below
   input wire eccr_pkg::eccr_rd_t rd_in,
   // Read result leaving toward the block above
   output eccr_pkg::eccr_rd_t rd_out,
   // APB configuration slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import eccr_pkg::*;

   // ------------------------------------------------------------
   // SECDED helpers
   // ------------------------------------------------------------

   // Spread data and low check bits over Hamming positions 1..71.
   function automatic logic [71:1] eccr_place(input logic [63:0] d, input logic [6:0] c);
      logic [71:1] cw;
      int j;
      int k;
      logic [6:0] pv;
      cw = '0;
      j = 0;
      k = 0;
      for (int p = 1; p < ECCR_WORD_W; p++) begin
         pv = 7'(p);
         if ((pv & (pv - 7'h01)) == 7'h00) begin
            cw[p] = c[j];
            j++;
         end else begin
            cw[p] = d[k];
            k++;
         end
      end
      return cw;
   endfunction

   // Gather data bits back out of a Hamming code word.
   function automatic logic [63:0] eccr_data_of(input logic [71:1] cw);
      logic [63:0] d;
      int k;
      logic [6:0] pv;
      d = '0;
      k = 0;
      for (int p = 1; p < ECCR_WORD_W; p++) begin
         pv = 7'(p);
         if ((pv & (pv - 7'h01)) != 7'h00) begin
            d[k] = cw[p];
            k++;
         end
      end
      return d;
   endfunction

   // Gather the seven position check bits back out of a code word.
   function automatic logic [6:0] eccr_chk_of(input logic [71:1] cw);
      logic [6:0] c;
      for (int j = 0; j < 7; j++) begin
         c[j] = cw[1 << j];
      end
      return c;
   endfunction

   // Syndrome of a code word; with zero check bits it is the encoding.
   function automatic logic [6:0] eccr_syndrome(input logic [71:1] cw);
      logic [6:0] s;
      logic [6:0] pv;
      s = '0;
      for (int p = 1; p < ECCR_WORD_W; p++) begin
         pv = 7'(p);
         for (int j = 0; j < 7; j++) begin
            if (pv[j]) begin
               s[j] = s[j] ^ cw[p];
            end
         end
      end
      return s;
   endfunction

   // Eight check bits: seven Hamming bits plus overall parity.
   function automatic logic [7:0] eccr_encode(input logic [63:0] d);
      logic [6:0] c;
      c = eccr_syndrome(eccr_place(d, 7'h00));
      return {(^d) ^ (^c), c};
   endfunction

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [ECCR_CTRL_W-1:0] ctrl;
   logic [ECCR_SEL_W-1:0] self_addr;
   logic [ECCR_SEL_W-1:0] self_mask;
   logic [ECCR_CNT_W-1:0] single_count;
   logic [ECCR_CNT_W-1:0] double_count;
   logic dec_en;
   logic enc_en;
   logic apb_setup;
   logic apb_write;
   logic mapped;

   assign dec_en = ctrl[ECCR_CTRL_DEC_EN]; // R10
   assign enc_en = ctrl[ECCR_CTRL_ENC_EN]; // R10
   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pwrite & ce;
   assign mapped = (paddr == ECCR_OFS_CTRL) || (paddr == ECCR_OFS_SELF_ADDR) ||
                   (paddr == ECCR_OFS_SELF_MASK) || (paddr == ECCR_OFS_STATUS);

   // The slave never waits; a frozen clock enable stretches the access.
   assign pready = ce;
   assign pslverr = psel & penable & ~mapped;

   // Software writes to the control, self address and mask words.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl <= ECCR_CTRL_RST;
         self_addr <= ECCR_SELF_ADDR_RST;
         self_mask <= ECCR_SELF_MASK_RST;
      end else if (apb_write) begin
         if (paddr == ECCR_OFS_CTRL) begin
            ctrl <= pwdata[ECCR_CTRL_W-1:0];
         end
         if (paddr == ECCR_OFS_SELF_ADDR) begin
            self_addr <= pwdata[ECCR_SEL_W-1:0];
         end
         if (paddr == ECCR_OFS_SELF_MASK) begin
            self_mask <= pwdata[ECCR_SEL_W-1:0];
         end
      end
   end

   // Read data is captured in the setup cycle so prdata leaves a flop.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata <= '0;
      end else if (ce && apb_setup && !pwrite) begin
         case (paddr)
            ECCR_OFS_CTRL: prdata <= 32'(ctrl);
            ECCR_OFS_SELF_ADDR: prdata <= 32'(self_addr);
            ECCR_OFS_SELF_MASK: prdata <= 32'(self_mask);
            ECCR_OFS_STATUS: prdata <= {double_count, single_count};
            default: prdata <= '0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Input stage and cascade pass-through
   // ------------------------------------------------------------
   eccr_req_t in_q;
   eccr_req_t req;
   logic selected;

   // Every request input, injection pins included, may be registered once.
   // The stage costs one cycle of latency on reads and writes alike.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         in_q <= '0;
      end else if (ce) begin
         in_q <= req_in;
      end
   end

   assign req = ctrl[ECCR_CTRL_IN_STAGE] ? in_q : req_in; // R15

   // Requests climb the column unchanged, so the chain forms a matrix.
   assign req_out = req; // R22

   // Zero mask bits ignore address bits, so one-hot self addresses with
   // a multi-bit address select several columns at once.
   // A self address bit left outside the mask can never match, so such a
   // block is never selected; keep self addresses inside their masks.
   assign selected = (req.addr[ECCR_ADDR_W-1:DEPTH_W] & self_mask) == self_addr; // R18 R21

   // ------------------------------------------------------------
   // Write path: encoder, injection, array
   // ------------------------------------------------------------
   logic [ECCR_WORD_W-1:0] mem [0:(1 << DEPTH_W)-1];
   logic [ECCR_WORD_W-1:0] enc_word;
   logic [ECCR_WORD_W-1:0] wr_word;
   logic [DEPTH_W-1:0] word_addr;
   logic do_write;
   logic do_read;

   assign word_addr = req.addr[DEPTH_W-1:0];
   assign do_write = ce & req.en & req.wr & selected;
   assign do_read = ce & req.en & ~req.wr & selected;

   // Upper input byte is dropped when the encoder makes the check bits.
   assign enc_word = enc_en ? {eccr_encode(req.din[ECCR_DATA_W-1:0]),
                               req.din[ECCR_DATA_W-1:0]} : req.din; // R1 R12

   // Injection follows the encoder so it works whatever the ECC setting.
   always_comb begin
      wr_word = enc_word;
      if (req.inject_double_error) begin // R8 R9
         wr_word[ECCR_INJ_LO] = ~enc_word[ECCR_INJ_LO];
         wr_word[ECCR_INJ_HI] = ~enc_word[ECCR_INJ_HI];
      end else if (req.inject_single_error) begin // R7 R9
         wr_word[ECCR_INJ_LO] = ~enc_word[ECCR_INJ_LO];
      end
   end

   // A lane left out keeps its old byte and so breaks the check bits of
   // that word; with ECC in use the fabric keeps every lane enabled.
   // Byte lanes 0..7 carry data, lane 8 the check byte.
   always_ff @(posedge clk) begin
      if (do_write) begin
         for (int b = 0; b < ECCR_LANES; b++) begin
            if (req.byte_write_mask[b]) begin // R17
               mem[word_addr][b*8 +: 8] <= wr_word[b*8 +: 8];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Read path: array register and pre-decode stage
   // ------------------------------------------------------------
   logic [ECCR_WORD_W-1:0] raw_q;
   logic raw_valid;
   logic [ECCR_WORD_W-1:0] pre_q;
   logic pre_valid;
   logic [ECCR_WORD_W-1:0] dec_in;
   logic dec_in_valid;

   // The array output is read only; nothing is ever written back.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         raw_q <= '0; // R6
         raw_valid <= 1'b0;
      end else if (ce) begin
         raw_valid <= do_read;
         if (do_read) begin
            raw_q <= mem[word_addr]; // R5
         end
      end
   end

   // Optional stage before the decoder; it keeps its word until a new read.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pre_q <= '0; // R6
         pre_valid <= 1'b0;
      end else if (ce) begin
         pre_valid <= raw_valid;
         if (raw_valid) begin
            pre_q <= raw_q;
         end
      end
   end

   assign dec_in = ctrl[ECCR_CTRL_PRE_STAGE] ? pre_q : raw_q; // R16
   assign dec_in_valid = ctrl[ECCR_CTRL_PRE_STAGE] ? pre_valid : raw_valid;

   // ------------------------------------------------------------
   // Decoder
   // ------------------------------------------------------------
   logic [71:1] dec_cw;
   logic [6:0] syn;
   logic parity_bad;
   eccr_rd_t dec_out;

   assign dec_cw = eccr_place(dec_in[ECCR_DATA_W-1:0], dec_in[ECCR_DATA_W +: 7]);
   assign syn = eccr_syndrome(dec_cw);
   // Overall parity tells one bad bit from two; the syndrome alone cannot,
   // since two errors may alias onto a valid position.
   assign parity_bad = ^dec_in;

   // Odd parity with a syndrome below 72 is one bad bit, check bits included;
   // even parity with a syndrome is two bad bits and the word is left raw.
   always_comb begin
      logic [71:1] fixed;
      logic [7:0] chk;
      fixed = dec_cw;
      chk = dec_in[ECCR_WORD_W-1:ECCR_DATA_W];
      dec_out.valid = dec_in_valid;
      dec_out.data = dec_in;
      dec_out.single_error_flag = 1'b0;
      dec_out.double_error_flag = 1'b0;
      if (dec_en) begin // R11
         if (parity_bad && syn == 7'h00) begin
            chk[ECCR_CHK_W-1] = ~chk[ECCR_CHK_W-1]; // R14
            dec_out.data = {chk, dec_in[ECCR_DATA_W-1:0]};
            dec_out.single_error_flag = 1'b1; // R3
         end else if (parity_bad && 32'(syn) < ECCR_WORD_W) begin
            fixed[syn] = ~dec_cw[syn]; // R2 R14
            dec_out.data = {chk[ECCR_CHK_W-1], eccr_chk_of(fixed), eccr_data_of(fixed)};
            dec_out.single_error_flag = 1'b1; // R3
         end else if (syn != 7'h00) begin
            dec_out.double_error_flag = 1'b1; // R2 R4 R14
         end
      end
   end

   // ------------------------------------------------------------
   // Post-decode stage and cascade merge
   // ------------------------------------------------------------
   eccr_rd_t post_q;
   eccr_rd_t own_rd;

   // Word and flags move together so each flag meets its own data.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         post_q <= '0; // R6
      end else if (ce) begin
         post_q.valid <= dec_out.valid;
         if (dec_out.valid) begin
            post_q.data <= dec_out.data; // R13
            post_q.single_error_flag <= dec_out.single_error_flag; // R13
            post_q.double_error_flag <= dec_out.double_error_flag; // R13
         end
      end
   end

   assign own_rd = ctrl[ECCR_CTRL_POST_STAGE] ? post_q : dec_out; // R16

   // A unique self address leaves one reading block per column; its
   // result replaces whatever climbs from below.
   assign rd_out = own_rd.valid ? own_rd : rd_in; // R19 R22

   // ------------------------------------------------------------
   // Error counters
   // ------------------------------------------------------------
   logic count_clear;
   logic single_event;
   logic double_event;

   // Only reads answered by this block count; results climbing from
   // below belong to the counters of another block.
   assign count_clear = apb_write && (paddr == ECCR_OFS_STATUS);
   assign single_event = own_rd.valid & own_rd.single_error_flag & (own_rd != post_q | ~ctrl[ECCR_CTRL_POST_STAGE] | post_q.valid);
   assign double_event = own_rd.valid & own_rd.double_error_flag;

   // Saturating counters; an event in the clearing cycle still counts.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         single_count <= '0;
         double_count <= '0;
      end else if (ce) begin
         if (count_clear) begin
            single_count <= ECCR_CNT_W'(single_event);
            double_count <= ECCR_CNT_W'(double_event);
         end else begin
            if (single_event && single_count != '1) begin
               single_count <= single_count + 1'b1;
            end
            if (double_event && double_count != '1) begin
               double_count <= double_count + 1'b1;
            end
         end
      end
   end

endmodule // eccr_port

// [bench/eccr_port_sva.sv]
// Checker for one ECC RAM port; sees only the top-level ports.
// Assumes configuration changes only through APB while reads are idle.
`timescale 1ns/1ps
module eccr_port_sva #(
   parameter int DEPTH_W = 12
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Data port
   input wire eccr_pkg::eccr_req_t req_in,
   input wire eccr_pkg::eccr_req_t req_out,
   input wire eccr_pkg::eccr_rd_t rd_in,
   input wire eccr_pkg::eccr_rd_t rd_out,
   // Configuration bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr
);
   import eccr_pkg::*;
   // ----
   // Shadow state
   // ----
   logic [4:0] ctrl;
   logic [10:0] slf;
   logic [10:0] msk;
   logic [2:0] hist;
   logic [1:0] tap;
   logic cfg;
   logic take;
   // Latency and selection are predicted from a copy of the settings.
   assign cfg = psel && penable && pwrite && pready;
   assign take = ce && req_out.en && !req_out.wr && ((req_out.addr[22:12] & msk) == slf);
   assign tap = {1'b0, ctrl[ECCR_CTRL_PRE_STAGE]} + {1'b0, ctrl[ECCR_CTRL_POST_STAGE]};
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl <= ECCR_CTRL_RST;
         slf <= ECCR_SELF_ADDR_RST;
         msk <= ECCR_SELF_MASK_RST;
      end else if (cfg && paddr == ECCR_OFS_CTRL) begin
         ctrl <= pwdata[4:0];
      end else if (cfg && paddr == ECCR_OFS_SELF_ADDR) begin
         slf <= pwdata[10:0];
      end else if (cfg && paddr == ECCR_OFS_SELF_MASK) begin
         msk <= pwdata[10:0];
      end
   end
   // Read tracker; it freezes with the clock enable, as the port does.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hist <= 3'h0;
      end else if (ce) begin
         hist <= {hist[1:0], take};
      end
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_reset_clears: assert property (disable iff (1'b0) !rst_n && ce |=> rd_out == rd_in)
      else $error("result not cleared by reset");
   chk_valid_timing: assert property (rd_out.valid == hist[tap])
      else $error("read valid at wrong cycle");
   chk_pass_below: assert property (!hist[tap] |-> rd_out == rd_in)
      else $error("result from below not passed on");
   chk_flags_apart: assert property (rd_out.valid |->
      !(rd_out.single_error_flag && rd_out.double_error_flag))
      else $error("both error flags high");
   chk_raw_flags: assert property (rd_out.valid && !ctrl[ECCR_CTRL_DEC_EN] |->
      !rd_out.single_error_flag && !rd_out.double_error_flag)
      else $error("flag raised with decoder off");
   chk_input_pass: assert property (!ctrl[ECCR_CTRL_IN_STAGE] |-> req_out == req_in)
      else $error("request altered without input stage");
   chk_input_stage: assert property (ctrl[2] && $past(ctrl[2]) && $past(req_in.en) |->
      req_out == $past(req_in))
      else $error("input stage not one cycle");
   chk_bad_offset: assert property (psel && penable && paddr > ECCR_OFS_STATUS |-> pslverr)
      else $error("unmapped offset not refused");
   cov_single: cover property (rd_out.valid && rd_out.single_error_flag);
   cov_double: cover property (rd_out.valid && rd_out.double_error_flag);
   cov_deep: cover property (rd_out.valid && ctrl == 5'h1f);
endmodule // eccr_port_sva
bind eccr_port eccr_port_sva #(.DEPTH_W(DEPTH_W)) eccr_port_sva_inst (
   .clk(clk), .rst_n(rst_n), .ce(ce), .req_in(req_in), .req_out(req_out), .rd_in(rd_in),
   .rd_out(rd_out), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .pslverr(pslverr)
);

// [bench/eccr_fabric.sv]
// Fabric model: drives requests into the port and stands in for the block below.
// Assumes the bench calls its task from one process at a time.
`timescale 1ns/1ps
module eccr_fabric (
   // Clock
   input wire logic clk,
   // Request out, result from the idle block below
   output eccr_pkg::eccr_req_t req,
   output eccr_pkg::eccr_rd_t below
);
   import eccr_pkg::*;
   initial begin
      req = '0;
      below = '0;
   end
   // The block below never reads, but its data and single flag keep moving so a leak shows.
   always @(posedge clk) begin
      below.data <= {below.data[70:0], ~below.data[71]};
      below.single_error_flag <= ~below.single_error_flag;
   end
   // One request per call; released data shows the inverse of the last word.
   task automatic issue(input logic w, input logic [22:0] a, input logic [71:0] d,
                        input logic si, input logic di);
      @(posedge clk);
      req.en <= 1'b1;
      req.wr <= w;
      req.addr <= a;
      req.din <= d;
      req.byte_write_mask <= 9'h1ff;
      req.inject_single_error <= si;
      req.inject_double_error <= di;
      @(posedge clk);
      req.en <= 1'b0;
      req.din <= ~d;
   endtask
endmodule // eccr_fabric

// [bench/tb_eccr_port.sv]
// Self-checking bench: ECC modes, injection, stages and block selection.
// Assumes the fabric model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_eccr_port;
   import eccr_pkg::*;
   localparam logic [4:0] MODES [8] = '{5'h03, 5'h02, 5'h01, 5'h00, 5'h1f, 5'h07, 5'h0b, 5'h13};
   logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   eccr_req_t req_in, req_out;
   eccr_rd_t rd_in, rd_out;
   int bad_count, cmp_count, cyc;
   int ns, nd;
   integer seed;
   logic [4:0] ctl;
   logic [10:0] slf, msk;
   logic [71:0] mem [int];
   logic [71:0] good [int];
   eccr_port #(.DEPTH_W(12)) eccr_port_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
      .req_in(req_in), .req_out(req_out), .rd_in(rd_in), .rd_out(rd_out), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   eccr_fabric eccr_fabric_inst (.clk(clk), .req(req_in), .below(rd_in));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // A hang ends the run as a failure.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         conclude();
      end
   end
   task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Hamming code: checks at power-of-two positions, top bit is overall parity.
   function automatic logic [71:0] enc(input logic [63:0] d);
      logic [71:0] w;
      int k;
      w = {8'h00, d};
      k = 0;
      for (int p = 1; p < 72; p++) begin
         if ((p & (p - 1)) != 0) begin
            for (int i = 0; i < 7; i++) if (p[i]) w[64 + i] ^= d[k];
            k++;
         end
      end
      w[71] = ^w[70:0];
      return w;
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Writes a word; the model keeps what the array must hold and the clean code.
   task automatic put(input logic [22:0] a, input logic [71:0] cw, input logic [71:0] em,
                      input logic si, input logic di);
      logic [71:0] st;
      logic [31:0] r;
      r = $random(seed);
      st = ctl[1] ? cw : cw ^ em;
      eccr_fabric_inst.issue(1'b1, a, ctl[1] ? {r[7:0], cw[63:0]} : st, si, di);
      if (di) st = st ^ (72'h1 << 30) ^ (72'h1 << 62);
      else if (si) st[30] = ~st[30];
      if ((a[22:12] & msk) == slf) begin
         mem[a[11:0]] = st;
         good[a[11:0]] = cw;
      end
   endtask
   task automatic get(input logic [22:0] a);
      logic [71:0] st;
      int n;
      st = mem[a[11:0]];
      n = $countones(st ^ good[a[11:0]]);
      eccr_fabric_inst.issue(1'b0, a, 72'h0, 1'b0, 1'b0);
      repeat (int'(ctl[2]) + int'(ctl[3]) + int'(ctl[4])) @(posedge clk);
      #1;
      if ((a[22:12] & msk) == slf) begin
         chk("valid", rd_out.valid, 1'b1);
         chk("data", rd_out.data, (ctl[0] && n == 1) ? good[a[11:0]] : st);
         chk("single", rd_out.single_error_flag, ctl[0] && n == 1);
         chk("double", rd_out.double_error_flag, ctl[0] && n == 2);
         if (ctl[0] && n == 1) ns++;
         if (ctl[0] && n == 2) nd++;
      end else begin
         chk("unselected", {rd_out.valid, rd_out.data}, {1'b0, rd_in.data});
      end
   endtask
   initial begin
      logic [31:0] r;
      logic e;
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'b1;
      seed = 32'h7576;
      {ctl, slf, msk} = {5'h03, 22'h0};
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("idle", rd_out.valid, 1'b0);
      for (int k = 0; k < 5; k++) begin
         apb(1'b0, 12'(k * 4), 32'h0, r, e);
         chk("reset value", r, (k == 0) ? ECCR_CTRL_RST : 5'h00);
         chk("slverr", e, k == 4);
      end
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, ECCR_OFS_CTRL, {27'h0, MODES[c]}, r, e);
         apb(1'b0, ECCR_OFS_CTRL, 32'h0, r, e);
         chk("ctrl", r, MODES[c]);
         ctl = MODES[c];
         for (int k = 0; k < 4; k++) begin
            put({11'h0, 12'(k)}, enc({$random(seed), $random(seed)}),
                (ctl == 5'h01 && k < 2) ? (72'h1 << (65 + k)) : 72'h0, k[0], k[1]);
         end
         repeat (2) for (int k = 0; k < 4; k++) get({11'h0, 12'(k)});
      end
      // Write-only broadcast setup; this port reads back one block only.
      apb(1'b1, ECCR_OFS_SELF_MASK, 32'h1, r, e);
      apb(1'b1, ECCR_OFS_SELF_ADDR, 32'h1, r, e);
      {msk, slf} = {11'h001, 11'h001};
      put({11'h003, 12'h005}, enc({$random(seed), $random(seed)}), 72'h0, 1'b0, 1'b0);
      put({11'h002, 12'h005}, enc({$random(seed), $random(seed)}), 72'h0, 1'b0, 1'b0);
      get({11'h001, 12'h005});
      get({11'h002, 12'h005});
      // Status counts this block's flagged reads; any write clears it.
      apb(1'b0, ECCR_OFS_STATUS, 32'h0, r, e);
      chk("status", r, {nd[15:0], ns[15:0]});
      apb(1'b1, ECCR_OFS_STATUS, 32'h0, r, e);
      apb(1'b0, ECCR_OFS_STATUS, 32'h0, r, e);
      chk("status clear", r, 32'h0);
      conclude();
   end
endmodule // tb_eccr_port
